// ===== common/fdltx_pkg.sv
// Shared constants and types for the data link transmitter.
// Assumes an APB host with 32-bit data and a same-clock line transmitter.
package fdltx_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_CODE   = 5'h04;
  localparam logic [4:0] OFS_TXDATA = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_MASK   = 5'h10;

  // Field positions
  localparam int ST_BREQ  = 0;
  localparam int ST_UDR   = 1;
  localparam int TXD_LAST = 8;
  localparam int RD_FULL  = 8;
  localparam int RD_BUSY  = 9;

  // Reset values
  localparam logic [3:0] CTRL_RST   = 4'h0;
  localparam logic [5:0] CODE_RST   = 6'h3F;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST   = 2'h0;

  // Link patterns
  localparam logic [5:0]  CODE_IDLE    = 6'h3F;
  localparam logic [7:0]  BOC_PREAMBLE = 8'hFF;
  localparam logic [7:0]  FLAG_CHAR    = 8'h7E;
  localparam logic [7:0]  ABORT_CHAR   = 8'hFE;
  localparam logic [7:0]  IDLE_CHAR    = 8'hFF;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_PRESET   = 16'hFFFF;
  localparam logic [2:0]  STUFF_RUN    = 3'h5;

  // Frame formats offered by the line transmitter
  localparam logic [1:0] FMT_ESF  = 2'h0;
  localparam logic [1:0] FMT_T1DM = 2'h1;
  localparam logic [1:0] FMT_SFDL = 2'h2;
  localparam logic [1:0] FMT_NONE = 2'h3;

  typedef struct packed {
    logic internal;
    logic abort;
    logic crc_en;
    logic en;
  } fdltx_ctrl_t;

  typedef struct packed {
    logic valid;
    logic data;
  } fdltx_dl_t;

  typedef enum logic [2:0] {HS_OFF, HS_FLAG, HS_DATA, HS_CRC, HS_ABORT} fdltx_hstate_t;

  function automatic logic [15:0] fdltx_rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

endpackage

// ===== core/fdltx_boc.sv
// Bit oriented code generator: repeats a 16-bit code pattern per link bit.
// Assumes tick is a one-cycle pulse on pclk, one per data link slot.
`timescale 1ns/1ps
module fdltx_boc import fdltx_pkg::*; (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       tick,
  input  wire logic [5:0] code,
  // Pattern out
  output logic            active,
  output logic            bit_o
);

  logic [3:0]  cnt;
  logic [5:0]  lat;
  logic [3:0]  next_cnt;
  logic [5:0]  next_lat;
  logic [15:0] pattern;

  // Code is latched only at pattern boundaries so a rewrite never tears a pattern
  always_comb begin
    pattern  = {BOC_PREAMBLE, 1'b0, lat, 1'b0};
    active   = (lat != CODE_IDLE);
    bit_o    = pattern[4'hF - cnt];
    next_cnt = cnt;
    next_lat = lat;
    if (tick) begin
      next_cnt = active ? 4'(cnt + 4'h1) : 4'h0;
      if (!active || cnt == 4'hF) begin
        next_lat = code;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      lat <= CODE_RST;
    end else begin
      cnt <= next_cnt;
      lat <= next_lat;
    end
  end

endmodule // fdltx_boc

// ===== core/fdltx_top.sv
// Data link transmitter: code generator, HDLC framer and external link source.
// Assumes APB on pclk and a line transmitter on pclk that pulses slot_req per link bit.
//
// Overview of operation
// - Send programmed six-bit codes; all ones stops
// - Pattern: eight ones, zero, code, zero
// - Code beats other content; yellow alarm beats code
// - HDLC frames only when internal transmitter selected
// - Enabled and idle: continuous flags
// - Double-buffered data; interrupt after each byte
// - After last byte: CRC or flag, then flags; a byte already buffered when the CRC ends starts the next frame with no flag
// - Insert zero after five ones in frame
// - Abort bit forces continuous abort characters
// - Empty buffer mid-frame: abort and underrun flag
// - Each event has own enable onto interrupt
// - Internal off: clock out, serial pin in
// - Slot offered in ESF, T1DM, superframe-datalink
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module fdltx_top import fdltx_pkg::*; #(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Line transmitter data link slot
  input  wire logic              slot_req,
  input  wire logic [1:0]        link_format,
  input  wire logic              yellow_active,
  input  wire logic              yellow_bit,
  output fdltx_dl_t              dl_out,
  // External link source
  input  wire logic              link_serial_in,
  output logic                   link_clock_out,
  // Interrupt
  output logic                   irq_out_n
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
    $error("fdltx_top: ADDR_W must be 5 to 32");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
    return (a == ADDR_W'(ofs));
  endfunction

  // Register state
  fdltx_ctrl_t ctrl;
  logic [5:0]  code;
  logic [1:0]  status;
  logic [1:0]  mask;
  fdltx_ctrl_t next_ctrl;
  logic [5:0]  next_code;
  logic [1:0]  next_status;
  logic [1:0]  next_mask;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_irq_out_n;

  // HDLC state
  fdltx_hstate_t hst;
  fdltx_hstate_t next_hst;
  logic [15:0]   sh;
  logic [15:0]   next_sh;
  logic [4:0]    cnt;
  logic [4:0]    next_cnt;
  logic [2:0]    ones;
  logic [2:0]    next_ones;
  logic [15:0]   crc;
  logic [15:0]   next_crc;
  logic [15:0]   crc_upd;
  logic          cur_last;
  logic          next_cur_last;
  logic [7:0]    hold;
  logic [7:0]    next_hold;
  logic          hold_full;
  logic          next_hold_full;
  logic          hold_last;
  logic          next_hold_last;
  logic          breq_ev;
  logic          udr_ev;
  logic          stuff_now;
  logic          hdlc_bit;

  // Link side
  logic        sync1;
  logic        sync2;
  logic        sync3;
  logic        ext_bit;
  logic        next_ext_bit;
  fdltx_dl_t   next_dl_out;
  logic        next_link_clock_out;
  logic        esf;
  logic        int_path;
  logic        boc_tick;
  logic        hdlc_tick;
  logic        boc_active;
  logic        boc_bit;
  logic        bus_wr;
  logic        wr_txdata;

  assign esf       = (link_format == FMT_ESF);
  assign int_path  = ctrl.internal && esf;
  assign boc_tick  = slot_req && esf && !yellow_active;
  assign hdlc_tick = boc_tick && int_path && !boc_active;
  assign bus_wr    = psel && penable && pwrite && pready;
  assign wr_txdata = bus_wr && hit(paddr, OFS_TXDATA);

  fdltx_boc u_boc (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (boc_tick),
    .code    (code),
    .active  (boc_active),
    .bit_o   (boc_bit)
  );

  // Register file and interrupt
  always_comb begin
    next_ctrl    = ctrl;
    next_code    = code;
    next_mask    = mask;
    next_status  = status;
    next_pready  = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (psel && penable && !pready) begin
      if (hit(paddr, OFS_CTRL)) begin
        next_prdata = {28'h000_0000, ctrl};
      end else if (hit(paddr, OFS_CODE)) begin
        next_prdata = {26'h000_0000, code};
      end else if (hit(paddr, OFS_TXDATA)) begin
        next_prdata = {22'h00_0000, (hst == HS_DATA || hst == HS_CRC), hold_full, hold};
      end else if (hit(paddr, OFS_STATUS)) begin
        next_prdata = {30'h0000_0000, status};
      end else if (hit(paddr, OFS_MASK)) begin
        next_prdata = {30'h0000_0000, mask};
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (bus_wr) begin
      if (hit(paddr, OFS_CTRL)) begin
        next_ctrl = fdltx_ctrl_t'(pwdata[3:0]);
      end
      if (hit(paddr, OFS_CODE)) begin
        next_code = pwdata[5:0];
      end
      if (hit(paddr, OFS_MASK)) begin
        next_mask = pwdata[1:0];
      end
      if (hit(paddr, OFS_STATUS)) begin
        next_status = status & ~pwdata[1:0];
      end
    end
    // A hardware event in the clearing cycle survives
    next_status[ST_BREQ] = next_status[ST_BREQ] | breq_ev;
    next_status[ST_UDR]  = next_status[ST_UDR] | udr_ev;
    next_irq_out_n       = ~|(next_status & next_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= fdltx_ctrl_t'(CTRL_RST);
      code      <= CODE_RST;
      status    <= STATUS_RST;
      mask      <= MASK_RST;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irq_out_n <= 1'b1;
    end else begin
      ctrl      <= next_ctrl;
      code      <= next_code;
      status    <= next_status;
      mask      <= next_mask;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      irq_out_n <= next_irq_out_n;
    end
  end

  // HDLC engine, advances one bit per granted slot
  always_comb begin
    stuff_now      = (ones == STUFF_RUN);
    hdlc_bit       = stuff_now ? 1'b0 : sh[0];
    crc_upd        = {crc[14:0], 1'b0} ^ ((crc[15] ^ sh[0]) ? CRC_POLY : 16'h0000);
    next_hst       = hst;
    next_sh        = sh;
    next_cnt       = cnt;
    next_ones      = ones;
    next_crc       = crc;
    next_cur_last  = cur_last;
    next_hold      = hold;
    next_hold_full = hold_full;
    next_hold_last = hold_last;
    breq_ev        = 1'b0;
    udr_ev         = 1'b0;
    if (hdlc_tick) begin
      if (stuff_now) begin
        next_ones = 3'h0;
      end else begin
        if (hst == HS_DATA) begin
          next_crc = crc_upd;
        end
        if (hst == HS_DATA || hst == HS_CRC) begin
          next_ones = sh[0] ? 3'(ones + 3'h1) : 3'h0;
        end else begin
          next_ones = 3'h0;
        end
        if (cnt > 5'h1) begin
          next_sh  = {1'b0, sh[15:1]};
          next_cnt = 5'(cnt - 5'h1);
        end else begin
          next_cnt = 5'h8;
          next_sh  = {8'h00, FLAG_CHAR};
          next_hst = HS_FLAG;
          if (ctrl.abort) begin
            next_hst = HS_ABORT;
            next_sh  = {8'h00, ABORT_CHAR};
          end else if (!ctrl.en) begin
            next_hst = HS_OFF;
            next_sh  = {8'h00, IDLE_CHAR};
          end else begin
            unique case (hst)
              HS_OFF, HS_FLAG, HS_CRC, HS_ABORT: begin
                if (hold_full) begin
                  next_hst       = HS_DATA;
                  next_sh        = {8'h00, hold};
                  next_crc       = CRC_PRESET;
                  next_cur_last  = hold_last;
                  next_hold_full = 1'b0;
                  breq_ev        = 1'b1;
                end
              end
              HS_DATA: begin
                if (cur_last) begin
                  if (ctrl.crc_en) begin
                    next_hst = HS_CRC;
                    next_sh  = fdltx_rev16(~crc_upd);
                    next_cnt = 5'h10;
                  end
                end else if (hold_full) begin
                  next_hst       = HS_DATA;
                  next_sh        = {8'h00, hold};
                  next_cur_last  = hold_last;
                  next_hold_full = 1'b0;
                  breq_ev        = 1'b1;
                end else begin
                  next_hst = HS_ABORT;
                  next_sh  = {8'h00, ABORT_CHAR};
                  udr_ev   = 1'b1;
                end
              end
            endcase
          end
        end
      end
    end
    // A write in the loading cycle refills the buffer; writes into a full buffer are dropped
    if (wr_txdata && (!hold_full || breq_ev)) begin
      next_hold      = pwdata[7:0];
      next_hold_last = pwdata[TXD_LAST];
      next_hold_full = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hst       <= HS_OFF;
      sh        <= {8'h00, IDLE_CHAR};
      cnt       <= 5'h1;
      ones      <= 3'h0;
      crc       <= CRC_PRESET;
      cur_last  <= 1'b0;
      hold      <= 8'h00;
      hold_full <= 1'b0;
      hold_last <= 1'b0;
    end else begin
      hst       <= next_hst;
      sh        <= next_sh;
      cnt       <= next_cnt;
      ones      <= next_ones;
      crc       <= next_crc;
      cur_last  <= next_cur_last;
      hold      <= next_hold;
      hold_full <= next_hold_full;
      hold_last <= next_hold_last;
    end
  end

  // Link output selection and external source
  always_comb begin
    next_ext_bit = (sync2 == sync3) ? sync3 : ext_bit;
    next_dl_out.valid = slot_req && (link_format != FMT_NONE);
    if (yellow_active && esf) begin
      next_dl_out.data = yellow_bit;
    end else if (boc_active && esf) begin
      next_dl_out.data = boc_bit;
    end else if (int_path) begin
      next_dl_out.data = hdlc_bit;
    end else begin
      next_dl_out.data = ext_bit;
    end
    next_link_clock_out = slot_req && !int_path && (link_format != FMT_NONE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1          <= 1'b0;
      sync2          <= 1'b0;
      sync3          <= 1'b0;
      ext_bit        <= 1'b0;
      dl_out         <= '0;
      link_clock_out <= 1'b0;
    end else begin
      sync1          <= link_serial_in;
      sync2          <= sync1;
      sync3          <= sync2;
      ext_bit        <= next_ext_bit;
      dl_out         <= next_dl_out;
      link_clock_out <= next_link_clock_out;
    end
  end

endmodule // fdltx_top

// ===== bench/fdltx_chk.sv
// Port checker for the data link transmitter.
// Assumes it is bound into fdltx_top and sees only its ports.
`timescale 1ns/1ps
module fdltx_chk import fdltx_pkg::*; #(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Link and interrupt
  input wire logic              slot_req,
  input wire logic [1:0]        link_format,
  input wire logic              yellow_active,
  input wire logic              yellow_bit,
  input wire fdltx_dl_t         dl_out,
  input wire logic              link_clock_out,
  input wire logic              irq_out_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; psel && penable && !pready; endsequence
  property p_ready; s_setup ##1 s_acc |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("bus answer late");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("ready held");
  property p_err; pready && paddr >= 'h14 |-> pslverr && prdata == 0; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_slot; slot_req && link_format != FMT_NONE |=> dl_out.valid; endproperty
  a_slot: assert property (p_slot) else $error("slot not served");
  property p_quiet; !slot_req |=> !dl_out.valid && !link_clock_out; endproperty
  a_quiet: assert property (p_quiet) else $error("bit without slot");
  property p_none; slot_req && link_format == FMT_NONE |=> !dl_out.valid && !link_clock_out; endproperty
  a_none: assert property (p_none) else $error("bit with no slot format");
  property p_yel; slot_req && link_format == FMT_ESF && yellow_active |=> dl_out.data == $past(yellow_bit); endproperty
  a_yel: assert property (p_yel) else $error("yellow lost");
  property p_t1dm; slot_req && link_format == FMT_T1DM |=> link_clock_out; endproperty
  a_t1dm: assert property (p_t1dm) else $error("no link clock");
  property p_mask; pready && pwrite && paddr == OFS_MASK && pwdata[1:0] == 2'h0 |-> ##2 irq_out_n; endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
endmodule // fdltx_chk

bind fdltx_top fdltx_chk #(.ADDR_W(ADDR_W)) fdltx_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .slot_req(slot_req), .link_format(link_format), .yellow_active(yellow_active),
  .yellow_bit(yellow_bit), .dl_out(dl_out), .link_clock_out(link_clock_out), .irq_out_n(irq_out_n));

// ===== bench/fdltx_line_model.sv
// Line transmitter model: paces link slots and records the bits it gets.
// Assumes the same pclk; fast gives back-to-back slots on alternate cycles.
`timescale 1ns/1ps
module fdltx_line_model import fdltx_pkg::*; (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fast,
  // Link slot
  input  wire fdltx_dl_t  dl_out,
  output logic            slot_req,
  output logic [31:0]     hist
);
  logic [2:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 3'h0;
      slot_req <= 1'b0;
      hist     <= 32'h0;
    end else begin
      cnt      <= cnt + 3'h1;
      slot_req <= fast ? cnt[0] : (cnt == 3'h7);
      // Newest bit lands in bit 0
      if (dl_out.valid) hist <= {hist[30:0], dl_out.data};
    end
  end
endmodule // fdltx_line_model

// ===== bench/testbench.sv
// Self-checking bench for the data link transmitter.
// Assumes the line model paces slots; APB driven from here.
`timescale 1ns/1ps
module testbench import fdltx_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic slot_req, yellow_active, yellow_bit, link_serial_in, link_clock_out, irq_out_n, fast;
  logic [4:0] paddr;
  logic [31:0] pwdata, prdata, q, hist;
  logic [1:0] link_format;
  fdltx_dl_t dl_out;
  int n_errors, tests_run;

  fdltx_top fdltx_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .slot_req(slot_req),
    .link_format(link_format), .yellow_active(yellow_active), .yellow_bit(yellow_bit), .dl_out(dl_out),
    .link_serial_in(link_serial_in), .link_clock_out(link_clock_out), .irq_out_n(irq_out_n));
  fdltx_line_model fdltx_line_model_inst (.pclk(pclk), .presetn(presetn), .fast(fast), .dl_out(dl_out),
    .slot_req(slot_req), .hist(hist));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Ends one cycle after release so the next call never re-drives in the same step
  task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic slots(input int n);
    repeat (n * 8) @(posedge pclk);
  endtask

  // True when the last w bits are one rotation of p and repeat once
  function automatic logic period_ok(input logic [31:0] h, input logic [15:0] p, input int w);
    logic [15:0] m;
    logic ok;
    m = (w == 16) ? 16'hFFFF : 16'h00FF;
    ok = 1'b0;
    for (int r = 0; r < w; r++) begin
      if ((h & m) == (((p << r) | (p >> (w - r))) & m) && ((h >> w) & m) == (h & m)) ok = 1'b1;
    end
    return ok;
  endfunction

  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 32'h0);
    check(q, 32'(CTRL_RST));
    apb(1'b0, OFS_CODE, 32'h0);
    check(q, 32'(CODE_RST));
    apb(1'b0, OFS_STATUS, 32'h0);
    check(q, 32'(STATUS_RST));
    apb(1'b1, OFS_MASK, 32'h0);
    apb(1'b0, OFS_MASK, 32'h0);
    check(q, 32'(MASK_RST));
    apb(1'b1, 5'h14, 32'hFFFF_FFFF);
    check(last_err, 1'b1);
    $display("register test done");
  endtask

  task automatic t_code();
    apb(1'b1, OFS_CODE, 32'h12);
    slots(40);
    check(period_ok(hist, 16'hFF24, 16), 1'b1);
    yellow_bit <= 1'b0;
    yellow_active <= 1'b1;
    slots(20);
    check(hist[15:0], 16'h0);
    yellow_active <= 1'b0;
    apb(1'b1, OFS_CODE, 32'h3F);
    slots(40);
    check(hist[15:0], 16'hFFFF);
    $display("code test done");
  endtask

  task automatic t_hdlc();
    fast <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'hB);
    slots(20);
    check(period_ok(hist, 16'h7E, 8), 1'b1);
    apb(1'b1, OFS_CTRL, 32'hF);
    slots(20);
    check(period_ok(hist, 16'h7F, 8), 1'b1);
    apb(1'b1, OFS_CTRL, 32'hB);
    slots(20);
    check(period_ok(hist, 16'h7E, 8), 1'b1);
    fast <= 1'b0;
    $display("idle and abort test done");
  endtask

  task automatic t_frame();
    apb(1'b1, OFS_MASK, 32'h3);
    apb(1'b1, OFS_TXDATA, 32'hA5);
    slots(40);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(q, 32'h3);
    check(irq_out_n, 1'b0);
    apb(1'b1, OFS_STATUS, 32'h3);
    apb(1'b0, OFS_STATUS, 32'h0);
    check({q[1:0], irq_out_n}, 3'h1);
    slots(20);
    check(period_ok(hist, 16'h7E, 8), 1'b1);
    apb(1'b1, OFS_MASK, 32'h2);
    apb(1'b1, OFS_TXDATA, 32'h13C);
    slots(60);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(q, 32'h1);
    check(irq_out_n, 1'b1);
    check(period_ok(hist, 16'h7E, 8), 1'b1);
    apb(1'b1, OFS_STATUS, 32'h1);
    $display("frame test done");
  endtask

  task automatic t_ext();
    apb(1'b1, OFS_CTRL, 32'h8);
    for (int f = 0; f < 3; f++) begin
      link_format <= 2'(f);
      link_serial_in <= 1'b0;
      slots(20);
      check(hist[7:0], (f == 0) ? 8'hFF : 8'h00);
      link_serial_in <= 1'b1;
      slots(20);
      check(hist[7:0], 8'hFF);
    end
    link_format <= FMT_NONE;
    // Let a bit already in flight land before taking the snapshot
    slots(1);
    q = hist;
    slots(8);
    check(hist, q);
    link_format <= FMT_ESF;
    $display("external source test done");
  endtask

  initial begin
    {presetn, psel, penable, pwrite, yellow_active, yellow_bit, fast} = 7'h0;
    {paddr, pwdata, link_format} = '0;
    link_serial_in = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_code();
    t_hdlc();
    t_frame();
    t_ext();
    print_verdict();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end
endmodule // testbench
